// *** design/ira_pkg.sv ***
// constants shared by the read-input / accumulator command block
// assumes one synchronous clock domain and byte-wide frame streams
package ira_pkg;

  // ***************************************************
  // frame layout
  // ***************************************************
  localparam logic [3:0] FRAME_LAST = 4'd8; // nine bytes, index 0..8
  localparam logic [3:0] CKSUM_IDX = 4'd8;
  localparam logic [3:0] IDX_ADDR = 4'd0;
  localparam logic [3:0] IDX_INSTR = 4'd1;
  localparam logic [3:0] IDX_TYPE = 4'd2;
  localparam logic [3:0] IDX_BANK = 4'd3;
  localparam logic [3:0] IDX_VAL3 = 4'd4;
  localparam logic [7:0] MODULE_ADDR_DEFAULT = 8'h01;
  localparam logic [7:0] HOST_ADDR = 8'h02;

  // ***************************************************
  // instructions and status codes
  // ***************************************************
  localparam logic [7:0] INSTR_READ_INPUT = 8'h0F;
  localparam logic [7:0] INSTR_ACCUMULATE = 8'h13;
  localparam logic [7:0] INSTR_COMPARE = 8'h14;
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_CKSUM = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
  localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;

  // ***************************************************
  // read-input banks and ports
  // ***************************************************
  localparam logic [7:0] BANK_DIGITAL = 8'h00;
  localparam logic [7:0] BANK_ANALOG = 8'h01;
  localparam logic [7:0] BANK_OUTPUTS = 8'h02;
  localparam logic [7:0] PORT_ALL = 8'hFF;
  localparam logic [7:0] PORT_LINES = 8'h08; // ports below this are single lines
  localparam logic [7:0] PORT_ANALOG_A = 8'h00;
  localparam logic [7:0] PORT_ANALOG_B = 8'h04;
  localparam logic [7:0] PORT_SUPPLY = 8'h08;
  localparam logic [7:0] PORT_TEMP_0 = 8'h09;
  localparam logic [7:0] PORT_TEMP_1 = 8'h0A;
  localparam logic [7:0] PORT_TEMP_2 = 8'h0B;

  // ***************************************************
  // accumulate operations and condition bits
  // ***************************************************
  localparam logic [7:0] OP_ADD = 8'h00;
  localparam logic [7:0] OP_SUB = 8'h01;
  localparam logic [7:0] OP_MUL = 8'h02;
  localparam logic [7:0] OP_DIV = 8'h03;
  localparam logic [7:0] OP_REMAINDER = 8'h04;
  localparam logic [7:0] OP_AND = 8'h05;
  localparam logic [7:0] OP_OR = 8'h06;
  localparam logic [7:0] OP_XOR = 8'h07;
  localparam logic [7:0] OP_NOT = 8'h08;
  localparam logic [7:0] OP_LOAD = 8'h09;
  localparam int COND_ZE = 0;
  localparam int COND_NZ = 1;
  localparam int COND_EQ = 2;
  localparam int COND_NE = 3;
  localparam int COND_GT = 4;
  localparam int COND_GE = 5;
  localparam int COND_LT = 6;
  localparam int COND_LE = 7;
  localparam logic [31:0] ACCUM_RESET = 32'h0000_0000;
  localparam logic [7:0] COND_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_RECEIVE = 2'b00,
    ST_EXECUTE = 2'b01,
    ST_REPLY = 2'b10
  } ira_state_t;

endpackage

// *** design/ira_alu.sv ***
// accumulator arithmetic and compare, purely combinational
// assumes the caller registers the result and flags
`timescale 1ns/1ps
module ira_alu (
  input wire logic [7:0] op, // operation code from the type byte
  input wire logic signed [31:0] acc, // current accumulator
  input wire logic signed [31:0] operand, // value field of the frame
  output logic signed [31:0] result, // new accumulator value
  output logic op_ok, // operation code known
  output logic eq, // accumulator equals operand
  output logic gt, // accumulator greater, signed
  output logic lt // accumulator lower, signed
);
  import ira_pkg::*;

  // ***************************************************
  // operation select
  // ***************************************************
  // divide by zero leaves the accumulator alone rather than inventing a value
  always_comb begin
    result = acc;
    op_ok = 1'b1;
    case (op)
      OP_ADD: result = acc + operand;
      OP_SUB: result = acc - operand;
      OP_MUL: result = acc * operand;
      OP_DIV: result = (operand != 32'sh0000_0000) ? acc / operand : acc;
      OP_REMAINDER: result = (operand != 32'sh0000_0000) ? acc % operand : acc;
      OP_AND: result = acc & operand;
      OP_OR: result = acc | operand;
      OP_XOR: result = acc ^ operand;
      OP_NOT: result = ~acc;
      OP_LOAD: result = operand;
      default: op_ok = 1'b0;
    endcase
  end

  // signed compare, operand is two's complement from the host
  always_comb begin
    eq = (acc == operand);
    gt = (acc > operand);
    lt = (acc < operand);
  end

endmodule

// *** design/ira_top.sv ***
// frame interpreter for read-input, accumulate and compare commands
// assumes byte streams synchronous to SYS_CLK and a host that waits for each reply
// Functional notes
// - instruction 0x0F reads an input, the type byte is the port and the bank byte the bank.
// - the reply carries host address, own address, status, instruction, four value bytes high first, checksum; 0x64 is success.
// - bank 0 ports 0 to 7 give each digital input as 0 or 1, the analog lines included.
// - bank 0 port 255 samples all eight inputs into the low eight accumulator bits.
// - bank 1 gives the two 12-bit conversions at ports 0 and 4, supply at 8 and temperatures at 9 to 11.
// - bank 2 ports 0 to 7 give the last set state of each digital output as 0 or 1.
// - instruction 19 applies the type-selected operation with the operand and stores the accumulator.
// - types 0 to 4 are add, subtract, multiply, divide and remainder.
// - types 5 to 9 are and, or, exclusive-or, invert and load.
// - an accumulate command is answered with status 100 in direct mode.
// - instruction 20 compares accumulator with operand and sets the flags, type and bank ignored.
// - in direct mode a read only answers, except bank 0 port 255; in standalone mode it is also copied to the accumulator.
// - the flags provide zero, not zero, equal, not equal, greater, greater-or-equal, lower, lower-or-equal.
`timescale 1ns/1ps
module ira_top #(
  parameter logic [7:0] MODULE_ADDR = ira_pkg::MODULE_ADDR_DEFAULT // own target address
) (
  input wire logic SYS_CLK, // system clock, 100 MHz
  input wire logic RESET, // synchronous reset, high
  input wire logic CE, // clock enable, freezes all state when low, but RESET high still clears it
  input wire logic RX_VALID, // command byte present
  input wire logic [7:0] RX_DATA, // command byte
  output logic RX_READY, // block takes command bytes
  output logic TX_VALID, // reply byte present
  output logic [7:0] TX_DATA, // reply byte
  input wire logic TX_READY, // host takes reply byte
  input wire logic STANDALONE, // high: standalone mode, low: direct mode
  input wire logic [7:0] DIG_IN, // general-purpose digital inputs
  input wire logic [11:0] ANALOG_A, // conversion result of first analog line
  input wire logic [11:0] ANALOG_B, // conversion result of second analog line
  input wire logic [15:0] SUPPLY_V, // supply voltage, tenths of a volt
  input wire logic [15:0] TEMP_0, // temperature, signed degrees
  input wire logic [15:0] TEMP_1, // temperature, signed degrees
  input wire logic [15:0] TEMP_2, // temperature, signed degrees
  input wire logic [7:0] OUT_STATE, // digital output states as last set
  output logic [31:0] ACCUM, // accumulator
  output logic [7:0] COND // jump conditions 0..7
);
  import ira_pkg::*;

  ira_state_t state, next_state;
  logic [7:0] rx_buf [0:8];
  logic [7:0] next_rx_buf [0:8];
  logic [7:0] tx_buf [0:8];
  logic [7:0] next_tx_buf [0:8];
  logic [3:0] cnt, next_cnt;
  logic next_rx_ready, next_tx_valid;
  logic [7:0] next_tx_data;
  logic [31:0] next_accum;
  logic [7:0] next_cond;
  logic [7:0] rx_sum, tx_sum, status;
  logic [31:0] operand, value;
  logic signed [31:0] alu_result;
  logic alu_ok, cmp_eq, cmp_gt, cmp_lt;

  // ***************************************************
  // arithmetic unit
  // ***************************************************
  assign operand = {rx_buf[IDX_VAL3], rx_buf[IDX_VAL3 + 4'd1], rx_buf[IDX_VAL3 + 4'd2],
                    rx_buf[IDX_VAL3 + 4'd3]};

  ira_alu u_alu (
    .op(rx_buf[IDX_TYPE]),
    .acc(ACCUM),
    .operand(operand),
    .result(alu_result),
    .op_ok(alu_ok),
    .eq(cmp_eq),
    .gt(cmp_gt),
    .lt(cmp_lt)
  );

  // ***************************************************
  // frame sequencer and command execution
  // ***************************************************
  // one frame at a time: receiving stops while a reply is pending
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_rx_ready = RX_READY;
    next_tx_valid = TX_VALID;
    next_tx_data = TX_DATA;
    next_accum = ACCUM;
    next_cond = COND;
    for (int i = 0; i < 9; i++) begin
      next_rx_buf[i] = rx_buf[i];
      next_tx_buf[i] = tx_buf[i];
    end
    rx_sum = 8'h00;
    tx_sum = 8'h00;
    status = STATUS_OK;
    value = 32'h0000_0000;
    case (state)
      ST_RECEIVE: begin
        if (RX_VALID && RX_READY) begin
          next_rx_buf[cnt] = RX_DATA;
          if (cnt == FRAME_LAST) begin
            next_cnt = 4'd0;
            next_rx_ready = 1'b0;
            next_state = ST_EXECUTE;
          end else begin
            next_cnt = 4'(cnt + 4'd1);
          end
        end
      end
      ST_EXECUTE: begin
        for (int i = 0; i < 8; i++) begin
          rx_sum = 8'(rx_sum + rx_buf[i]);
        end
        if (rx_buf[IDX_ADDR] != MODULE_ADDR) begin
          // frames for another module are dropped without a reply
          next_rx_ready = 1'b1;
          next_state = ST_RECEIVE;
        end else begin
          if (rx_sum != rx_buf[CKSUM_IDX]) begin
            status = STATUS_BAD_CKSUM;
          end else begin
            case (rx_buf[IDX_INSTR])
              INSTR_READ_INPUT: begin
                case (rx_buf[IDX_BANK])
                  BANK_DIGITAL: begin
                    if (rx_buf[IDX_TYPE] == PORT_ALL) begin
                      value = {24'h00_0000, DIG_IN};
                      next_accum = {ACCUM[31:8], DIG_IN};
                    end else if (rx_buf[IDX_TYPE] < PORT_LINES) begin
                      value = {31'h0000_0000, DIG_IN[rx_buf[IDX_TYPE][2:0]]};
                    end else begin
                      status = STATUS_BAD_TYPE;
                    end
                  end
                  BANK_ANALOG: begin
                    case (rx_buf[IDX_TYPE])
                      PORT_ANALOG_A: value = {20'h0_0000, ANALOG_A};
                      PORT_ANALOG_B: value = {20'h0_0000, ANALOG_B};
                      PORT_SUPPLY: value = {16'h0000, SUPPLY_V};
                      PORT_TEMP_0: value = {{16{TEMP_0[15]}}, TEMP_0};
                      PORT_TEMP_1: value = {{16{TEMP_1[15]}}, TEMP_1};
                      PORT_TEMP_2: value = {{16{TEMP_2[15]}}, TEMP_2};
                      default: status = STATUS_BAD_TYPE;
                    endcase
                  end
                  BANK_OUTPUTS: begin
                    if (rx_buf[IDX_TYPE] < PORT_LINES) begin
                      value = {31'h0000_0000, OUT_STATE[rx_buf[IDX_TYPE][2:0]]};
                    end else begin
                      status = STATUS_BAD_TYPE;
                    end
                  end
                  default: status = STATUS_BAD_VALUE;
                endcase
                // the port-255 case already wrote the accumulator itself
                if (STANDALONE && status == STATUS_OK && rx_buf[IDX_TYPE] != PORT_ALL) begin
                  next_accum = value;
                end
              end
              INSTR_ACCUMULATE: begin
                value = operand; // reply echoes the operand
                if (alu_ok) begin
                  next_accum = alu_result;
                  next_cond[COND_ZE] = (alu_result == 32'sh0000_0000);
                  next_cond[COND_NZ] = (alu_result != 32'sh0000_0000);
                end else begin
                  status = STATUS_BAD_TYPE;
                end
              end
              INSTR_COMPARE: begin
                value = operand;
                next_cond[COND_ZE] = cmp_eq;
                next_cond[COND_NZ] = !cmp_eq;
                next_cond[COND_EQ] = cmp_eq;
                next_cond[COND_NE] = !cmp_eq;
                next_cond[COND_GT] = cmp_gt;
                next_cond[COND_GE] = cmp_gt || cmp_eq;
                next_cond[COND_LT] = cmp_lt;
                next_cond[COND_LE] = cmp_lt || cmp_eq;
              end
              default: status = STATUS_BAD_CMD;
            endcase
          end
          // reply frame assembled in one go, status OK is 100
          next_tx_buf[0] = HOST_ADDR;
          next_tx_buf[1] = MODULE_ADDR;
          next_tx_buf[2] = status;
          next_tx_buf[3] = rx_buf[IDX_INSTR];
          next_tx_buf[4] = value[31:24];
          next_tx_buf[5] = value[23:16];
          next_tx_buf[6] = value[15:8];
          next_tx_buf[7] = value[7:0];
          for (int i = 0; i < 8; i++) begin
            tx_sum = 8'(tx_sum + next_tx_buf[i]);
          end
          next_tx_buf[8] = tx_sum;
          next_tx_data = next_tx_buf[0];
          next_tx_valid = 1'b1;
          next_cnt = 4'd0;
          next_state = ST_REPLY;
        end
      end
      ST_REPLY: begin
        if (TX_VALID && TX_READY) begin
          if (cnt == FRAME_LAST) begin
            next_tx_valid = 1'b0;
            next_cnt = 4'd0;
            next_rx_ready = 1'b1;
            next_state = ST_RECEIVE;
          end else begin
            next_cnt = 4'(cnt + 4'd1);
            next_tx_data = tx_buf[4'(cnt + 4'd1)];
          end
        end
      end
      default: begin
        next_state = ST_RECEIVE;
        next_cnt = 4'd0;
        next_rx_ready = 1'b1;
        next_tx_valid = 1'b0;
      end
    endcase
  end

  // ***************************************************
  // state registers
  // ***************************************************
  // buffers are cleared on reset along with the rest of the state
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state <= ST_RECEIVE;
      cnt <= 4'd0;
      RX_READY <= 1'b1;
      TX_VALID <= 1'b0;
      TX_DATA <= 8'h00;
      ACCUM <= ACCUM_RESET;
      COND <= COND_RESET;
      for (int i = 0; i < 9; i++) begin
        rx_buf[i] <= 8'h00;
        tx_buf[i] <= 8'h00;
      end
    end else if (CE) begin
      state <= next_state;
      cnt <= next_cnt;
      RX_READY <= next_rx_ready;
      TX_VALID <= next_tx_valid;
      TX_DATA <= next_tx_data;
      ACCUM <= next_accum;
      COND <= next_cond;
      for (int i = 0; i < 9; i++) begin
        rx_buf[i] <= next_rx_buf[i];
        tx_buf[i] <= next_tx_buf[i];
      end
    end
  end

endmodule

// *** bench/ira_top_assertions.sv ***
// checker for the frame interpreter, watching only top-level ports
// assumes CE held high, so reply timing is fixed
`timescale 1ns/1ps
module ira_top_assertions (
  input wire logic SYS_CLK, // clock
  input wire logic RESET, // sync reset, high
  input wire logic RX_READY, // command byte taken
  input wire logic TX_VALID, // reply byte present
  input wire logic [7:0] TX_DATA, // reply byte
  input wire logic TX_READY, // reply byte taken
  input wire logic [31:0] ACCUM, // accumulator
  input wire logic [7:0] COND // jump conditions
);
  import ira_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // ********
  // reply byte count and running sum
  // ********
  logic [3:0] n_out;
  logic [7:0] sum;
  logic [3:0] next_n_out;
  logic [7:0] next_sum;
  logic last;
  assign last = TX_VALID && TX_READY && n_out == 4'h8;
  // sum restarts each reply, so a lost byte shows at the checksum
  always_comb begin
    next_n_out = n_out;
    next_sum = sum;
    if (RESET || last) begin
      next_n_out = 4'h0;
      next_sum = 8'h00;
    end else if (TX_VALID && TX_READY) begin
      next_n_out = n_out + 4'h1;
      next_sum = sum + TX_DATA;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    n_out <= next_n_out;
    sum <= next_sum;
  end
  // ********
  // properties
  // ********
  property p_no_rx_in_tx; TX_VALID |-> !RX_READY; endproperty
  a_no_rx_in_tx: assert property (p_no_rx_in_tx) else $error("byte taken during reply");
  property p_tx_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped");
  property p_host_first; $rose(TX_VALID) |-> TX_DATA == HOST_ADDR; endproperty
  a_host_first: assert property (p_host_first) else $error("reply not led by host address");
  property p_reply_soon; $fell(RX_READY) |=> TX_VALID || RX_READY; endproperty
  a_reply_soon: assert property (p_reply_soon) else $error("reply late");
  property p_cksum; last |-> TX_DATA == sum; endproperty
  a_cksum: assert property (p_cksum) else $error("reply checksum wrong");
  property p_done; last |=> RX_READY && !TX_VALID; endproperty
  a_done: assert property (p_done) else $error("reply not ended after nine bytes");
  property p_acc_hold; RX_READY || TX_VALID |=> $stable(ACCUM) && $stable(COND); endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("state moved outside execute");
  property p_zero; $changed(COND[1:0]) |-> COND[1] == !COND[0]; endproperty
  a_zero: assert property (p_zero) else $error("zero flags inconsistent");
  property p_cmp; $changed(COND[7:2]) |-> COND[3] == !COND[2] && COND[5] == (COND[4] || COND[2])
    && COND[7] == (COND[6] || COND[2]); endproperty
  a_cmp: assert property (p_cmp) else $error("compare flags inconsistent");
endmodule

bind ira_top ira_top_assertions i_chk (.SYS_CLK, .RESET, .RX_READY, .TX_VALID, .TX_DATA, .TX_READY,
  .ACCUM, .COND);

// *** bench/ira_host.sv ***
// host model: sends nine-byte frames and takes the replies
// assumes handshakes sampled on the rising edge; drives on falling edges
`timescale 1ns/1ps
module ira_host (
  input wire logic clk, // system clock
  input wire logic rx_ready, // block takes a byte
  output logic rx_valid, // command byte present
  output logic [7:0] rx_data, // command byte
  input wire logic tx_valid, // reply byte present
  input wire logic [7:0] tx_data, // reply byte
  output logic tx_ready // reply byte taken
);
  bit slow = 1'b0; // stall two cycles before each reply byte
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // ********
  // frame transfer
  // ********
  // bytes held until a rising edge sees ready high
  task automatic xfer(input logic [7:0] b [9], output logic [7:0] r [9], output bit got, output bit to);
    int n;
    got = 1'b0;
    to = 1'b0;
    for (int i = 0; i < 9; i++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = b[i];
      n = 0;
      while (!rx_ready && n < 50) begin
        @(negedge clk);
        n++;
      end
      to |= (n >= 50);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data; // released line must not look valid
    for (int i = 0; i < 9; i++) begin
      n = 0;
      while (!tx_valid && n < 50) begin
        @(negedge clk);
        n++;
      end
      if (!tx_valid) begin
        tx_ready = 1'b0;
        return;
      end
      r[i] = tx_data;
      // ready stays up between bytes unless slow lowers it for two cycles, so it is never lowered and raised in one step
      if (slow) begin
        tx_ready = 1'b0;
        repeat (2) @(negedge clk);
      end
      tx_ready = 1'b1;
      @(negedge clk);
    end
    tx_ready = 1'b0;
    got = 1'b1;
  endtask
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the frame interpreter
// assumes the host model and checker are compiled alongside
`timescale 1ns/1ps
module tb_top;
  import ira_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RESET = 1'b1;
  logic CE = 1'b1; // held high so reply timing stays fixed
  logic STANDALONE = 1'b0;
  logic [7:0] DIG_IN = 8'hA5;
  logic [7:0] OUT_STATE = 8'h3C;
  logic [11:0] ANALOG_A = 12'h12E;
  logic [11:0] ANALOG_B = 12'hFFF;
  logic [15:0] SUPPLY_V = 16'h00F0;
  logic [15:0] TEMP_0 = 16'hFFF6;
  logic [15:0] TEMP_1 = 16'h0019;
  logic [15:0] TEMP_2 = 16'h8000;
  logic RX_VALID, RX_READY, TX_VALID, TX_READY;
  logic [7:0] RX_DATA, TX_DATA, COND;
  logic [31:0] ACCUM;
  int n_mismatch = 0;
  int tests_run = 0;
  always #5 SYS_CLK = ~SYS_CLK;
  ira_top i_ira_top (.SYS_CLK, .RESET, .CE, .RX_VALID, .RX_DATA, .RX_READY, .TX_VALID, .TX_DATA,
    .TX_READY, .STANDALONE, .DIG_IN, .ANALOG_A, .ANALOG_B, .SUPPLY_V, .TEMP_0, .TEMP_1, .TEMP_2,
    .OUT_STATE, .ACCUM, .COND);
  ira_host i_ira_host (.clk(SYS_CLK), .rx_ready(RX_READY), .rx_valid(RX_VALID), .rx_data(RX_DATA),
    .tx_valid(TX_VALID), .tx_data(TX_DATA), .tx_ready(TX_READY));
  // ********
  // checking helpers
  // ********
  task chk(input logic [39:0] a, input logic [39:0] e, input string m);
    tests_run++;
    if (a !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one frame through the host; a lost handshake ends the run
  task automatic cmd(input logic [7:0] ad, ins, ty, bk, input logic [31:0] v, input logic [7:0] bad,
    output logic [7:0] st, output logic [31:0] rv);
    logic [7:0] b [9];
    logic [7:0] r [9];
    logic [7:0] s;
    bit got, to;
    b = '{ad, ins, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    s = 8'h00;
    for (int i = 0; i < 8; i++) s += b[i];
    b[8] = s + bad;
    i_ira_host.xfer(b, r, got, to);
    if (to || got != (ad == MODULE_ADDR_DEFAULT)) begin
      chk(40'h0, 40'h1, "handshake or reply presence");
      end_sim;
    end
    st = r[2];
    rv = {r[4], r[5], r[6], r[7]};
    s = 8'h00;
    for (int i = 0; i < 8; i++) s += r[i];
    if (got) chk({r[0], r[1], r[3], r[8]}, {HOST_ADDR, ad, ins, s}, "reply frame");
  endtask
  task automatic op(input logic [7:0] ins, ty, bk, input logic [31:0] v, output logic [7:0] st,
    output logic [31:0] rv);
    cmd(MODULE_ADDR_DEFAULT, ins, ty, bk, v, 8'h00, st, rv);
  endtask
  // ********
  // scenarios
  // ********
  task automatic s_inputs;
    logic [7:0] st;
    logic [31:0] rv;
    logic [7:0] pt [6] = '{8'h00, 8'h04, 8'h08, 8'h09, 8'h0A, 8'h0B};
    logic [31:0] ex [6];
    ex = '{{20'h0, ANALOG_A}, {20'h0, ANALOG_B}, {16'h0, SUPPLY_V}, {{16{TEMP_0[15]}}, TEMP_0},
      {{16{TEMP_1[15]}}, TEMP_1}, {{16{TEMP_2[15]}}, TEMP_2}};
    op(INSTR_ACCUMULATE, OP_LOAD, 8'h00, 32'h12345600, st, rv);
    for (int p = 0; p < 8; p++) begin
      op(INSTR_READ_INPUT, 8'(p), BANK_DIGITAL, 32'h0, st, rv);
      chk({st, rv}, {STATUS_OK, 31'h0, DIG_IN[p]}, "digital line");
      chk(ACCUM, 32'h12345600, "direct read moved accumulator");
    end
    for (int k = 0; k < 6; k++) begin
      op(INSTR_READ_INPUT, pt[k], BANK_ANALOG, 32'h0, st, rv);
      chk({st, rv}, {STATUS_OK, ex[k]}, "analog channel");
    end
    op(INSTR_READ_INPUT, PORT_ALL, BANK_DIGITAL, 32'h0, st, rv);
    chk(rv, {24'h0, DIG_IN}, "all inputs value");
    chk(ACCUM, {24'h123456, DIG_IN}, "all inputs into accumulator");
  endtask
  task automatic s_outputs;
    logic [7:0] st;
    logic [31:0] rv;
    @(negedge SYS_CLK);
    STANDALONE = 1'b1;
    i_ira_host.slow = 1'b1;
    for (int p = 0; p < 8; p++) begin
      op(INSTR_READ_INPUT, 8'(p), BANK_OUTPUTS, 32'h0, st, rv);
      chk({st, rv}, {STATUS_OK, 31'h0, OUT_STATE[p]}, "output state");
      chk(ACCUM, {31'h0, OUT_STATE[p]}, "standalone copy");
    end
    STANDALONE = 1'b0;
    i_ira_host.slow = 1'b0;
  endtask
  task automatic s_accumulate_cmd_a;
    logic [7:0] st;
    logic [31:0] rv;
    logic [31:0] a [10] = '{32'h7, 32'h5, 32'h3, 32'hFFFFFFF9, 32'hFFFFFFF9, 32'hF0F0, 32'hF0F0,
      32'hFF00, 32'hFFFF, 32'h0};
    logic [31:0] b [10] = '{32'hFFFFFFF9, 32'h9, 32'hFFFFEC78, 32'h2, 32'h2, 32'hFF00, 32'h0F0F,
      32'h0FF0, 32'h55, 32'h80000000};
    logic [31:0] e [10] = '{32'h0, 32'hFFFFFFFC, 32'hFFFFC568, 32'hFFFFFFFD, 32'hFFFFFFFF, 32'hF000,
      32'hFFFF, 32'hF0F0, 32'hFFFF0000, 32'h80000000};
    for (int k = 0; k < 10; k++) begin
      op(INSTR_ACCUMULATE, OP_LOAD, 8'h00, a[k], st, rv);
      op(INSTR_ACCUMULATE, 8'(k), 8'h00, b[k], st, rv);
      chk({st, rv}, {STATUS_OK, b[k]}, "accumulate_cmd_a reply");
      chk(ACCUM, e[k], "accumulate_cmd_a result");
      chk(COND[1:0], {e[k] != 0, e[k] == 0}, "zero flags");
    end
  endtask
  task automatic s_compare;
    logic [7:0] st;
    logic [31:0] rv;
    logic eq, gt, lt;
    logic [31:0] b [4] = '{32'h3E7, 32'h3E8, 32'h3E9, 32'hFFFFFFFB};
    op(INSTR_ACCUMULATE, OP_LOAD, 8'h00, 32'h3E8, st, rv);
    for (int k = 0; k < 4; k++) begin
      op(INSTR_COMPARE, 8'h07, 8'h02, b[k], st, rv);
      eq = (b[k] == 32'h3E8);
      gt = (32'sh3E8 > $signed(b[k]));
      lt = !eq && !gt;
      chk({st, rv}, {STATUS_OK, b[k]}, "compare reply");
      chk(COND, {lt | eq, lt, gt | eq, gt, !eq, eq, !eq, eq}, "compare flags");
      chk(ACCUM, 32'h3E8, "compare moved accumulator");
    end
  endtask
  task automatic s_errors;
    logic [7:0] st;
    logic [31:0] rv;
    op(INSTR_ACCUMULATE, OP_LOAD, 8'h00, 32'h55, st, rv);
    cmd(MODULE_ADDR_DEFAULT, INSTR_ACCUMULATE, OP_ADD, 8'h00, 32'h1, 8'h01, st, rv);
    chk({st, rv}, {STATUS_BAD_CKSUM, 32'h0}, "bad checksum");
    cmd(8'h07, INSTR_ACCUMULATE, OP_ADD, 8'h00, 32'h1, 8'h00, st, rv);
    op(INSTR_ACCUMULATE, 8'h0A, 8'h00, 32'h1, st, rv);
    // the reply still echoes the operand when the operation code is unknown
    chk({st, rv}, {STATUS_BAD_TYPE, 32'h1}, "accumulate_cmd_a type ten");
    op(INSTR_READ_INPUT, 8'h00, 8'h03, 32'h0, st, rv);
    chk({st, rv}, {STATUS_BAD_VALUE, 32'h0}, "bank three");
    op(8'h05, 8'h00, 8'h00, 32'h0, st, rv);
    chk({st, rv}, {STATUS_BAD_CMD, 32'h0}, "unknown command");
    chk(ACCUM, 32'h55, "errors moved accumulator");
  endtask
  // ********
  // main sequence
  // ********
  initial begin
    repeat (8) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    RESET = 1'b0;
    s_inputs;
    s_outputs;
    s_accumulate_cmd_a;
    s_compare;
    s_errors;
    end_sim;
  end
endmodule
